// ===== ofc_defines.svh
// Constants for the out-of-band flow control link
`ifndef OFC_DEFINES_SVH
`define OFC_DEFINES_SVH

// Link word sizes
`define OFC_LANES            8
`define OFC_CAL_W            16
`define OFC_STAT_W           9

// Bit counts within a frame
`define OFC_CAL_LAST         6'h0f
`define OFC_CRC_LAST         6'h03
`define OFC_STAT_LAST        6'h08
`define OFC_CAL_BITS         6'h10
`define OFC_STAT_BITS        6'h09
`define OFC_CAL_FRAME_LAST   6'h13
`define OFC_STAT_FRAME_LAST  6'h0c

// Check code
`define OFC_CRC_INIT         4'hf
`define OFC_CRC_POLY         4'h3

// Register offsets
`define OFC_ADR_CTRL         8'h00
`define OFC_ADR_TX_SNAP      8'h04
`define OFC_ADR_RX_CAL       8'h08
`define OFC_ADR_RX_STAT      8'h0c
`define OFC_ADR_EVENTS       8'h10

// Field positions and reset values
`define OFC_CTRL_RUN         0
`define OFC_CTRL_RESET       1'h0
`define OFC_EVENTS_RESET     4'h0

`endif

// ===== ofc_pkg.sv
// Types and check code step for the out-of-band flow control link
package ofc_pkg;
`include "ofc_defines.svh"

    typedef enum logic [1:0] {TX_CAL, TX_CAL_CRC, TX_STAT, TX_STAT_CRC}
        ofc_tx_phase_t;

    typedef enum logic [1:0] {RX_HUNT, RX_CAL, RX_STAT} ofc_rx_phase_t;

    typedef struct packed {
        logic                   line_clk;
        logic                   ser_bit;
        logic                   mark;
        ofc_tx_phase_t          phase;
        logic [5:0]             cnt;
        logic [15:0]            shreg;
        logic [3:0]             crc;
        logic                   with_stat;
        logic [`OFC_STAT_W-1:0] stat;
        logic [15:0]            snap_cal;
        logic                   run;
        logic [3:0]             events;
        logic                   ack;
        logic [31:0]            dat;
    } ofc_top_state_t;

    typedef struct packed {
        logic [2:0]             s1;
        logic [2:0]             s2;
        logic                   clk_d;
        ofc_rx_phase_t          phase;
        logic [5:0]             cnt;
        logic [15:0]            sh;
        logic [3:0]             crc;
        logic [15:0]            calendar;
        logic [`OFC_LANES-1:0]  lane;
        logic                   link;
        logic                   cal_upd;
        logic                   cal_err;
        logic                   st_upd;
        logic                   st_err;
    } ofc_rx_state_t;

    function automatic logic [3:0] ofc_crc_step(input logic [3:0] crc,
                                                input logic       b);
        logic fb;
        fb = crc[3] ^ b;
        ofc_crc_step = {crc[2:0], 1'b0} ^ (fb ? `OFC_CRC_POLY : 4'h0);
    endfunction

endpackage

// ===== ofc_rx_core.sv
// Receive end: samples the incoming link and recovers calendar and status
`timescale 1ns/1ps
`include "ofc_defines.svh"

module ofc_rx_core
    import ofc_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  oob_rx_line_clock_i,
    input  wire logic                  oob_rx_serial_bit_i,
    input  wire logic                  oob_rx_frame_mark_i,
    output logic [15:0]                calendar_o,
    output logic [`OFC_LANES-1:0]      lane_status_o,
    output logic                       link_status_o,
    output logic                       calendar_update_o,
    output logic                       calendar_error_o,
    output logic                       status_update_o,
    output logic                       status_error_o
);

    ofc_rx_state_t cur;
    ofc_rx_state_t nxt;
    logic          rise;
    logic          b;
    logic          m;
    logic [15:0]   sh;
    logic [3:0]    crc;

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        nxt      = cur;
        nxt.s1   = {oob_rx_frame_mark_i, oob_rx_serial_bit_i,
                    oob_rx_line_clock_i};
        nxt.s2   = cur.s1;
        nxt.clk_d = cur.s2[0];
        rise     = cur.s2[0] & ~cur.clk_d;
        b        = cur.s2[1];
        m        = cur.s2[2];
        sh       = cur.sh;
        crc      = cur.crc;
        nxt.cal_upd = 1'b0;
        nxt.cal_err = 1'b0;
        nxt.st_upd  = 1'b0;
        nxt.st_err  = 1'b0;
        if (rise)
        begin
            if (m)
            begin
                // Frame start restarts the receiver
                sh        = {cur.sh[14:0], b};
                crc       = ofc_crc_step(`OFC_CRC_INIT, b);
                nxt.cnt   = 6'h01;
                nxt.phase = RX_CAL;
            end
            else
            begin
                case (cur.phase)
                    RX_CAL:
                    begin
                        if (cur.cnt < `OFC_CAL_BITS)
                            sh = {cur.sh[14:0], b};
                        crc = ofc_crc_step(cur.crc, b);
                        if (cur.cnt == `OFC_CAL_FRAME_LAST)
                        begin
                            nxt.calendar = sh;
                            nxt.cal_upd  = (crc == 4'h0);
                            nxt.cal_err  = (crc != 4'h0);
                            nxt.phase    = RX_STAT;
                            nxt.cnt      = 6'h00;
                            crc          = `OFC_CRC_INIT;
                        end
                        else
                            nxt.cnt = cur.cnt + 6'h01;
                    end
                    RX_STAT:
                    begin
                        if (cur.cnt < `OFC_STAT_BITS)
                            sh = {cur.sh[14:0], b};
                        crc = ofc_crc_step(cur.crc, b);
                        if (cur.cnt == `OFC_STAT_FRAME_LAST)
                        begin
                            nxt.lane   = sh[`OFC_LANES-1:0];
                            nxt.link   = sh[`OFC_LANES];
                            nxt.st_upd = (crc == 4'h0);
                            nxt.st_err = (crc != 4'h0);
                            nxt.phase  = RX_HUNT;
                        end
                        else
                            nxt.cnt = cur.cnt + 6'h01;
                    end
                    default:
                    begin
                        nxt.phase = RX_HUNT;
                    end
                endcase
            end
        end
        nxt.sh  = sh;
        nxt.crc = crc;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cur <= '0;
        else
            cur <= nxt;
    end

    assign calendar_o        = cur.calendar;
    assign lane_status_o     = cur.lane;
    assign link_status_o     = cur.link;
    assign calendar_update_o = cur.cal_upd;
    assign calendar_error_o  = cur.cal_err;
    assign status_update_o   = cur.st_upd;
    assign status_error_o    = cur.st_err;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_cal_flag_cause: assert property (
        (cur.cal_upd || cur.cal_err) |->
            !(cur.cal_upd && cur.cal_err) && $past(cur.phase) == RX_CAL
            && $past(cur.cnt) == `OFC_CAL_FRAME_LAST)
        else $error("calendar flag without a finished calendar");

    chk_stat_flag_cause: assert property (
        (cur.st_upd || cur.st_err) |->
            !(cur.st_upd && cur.st_err) && $past(cur.phase) == RX_STAT)
        else $error("status flag without a finished status word");

    chk_sample_on_rise: assert property (
        $changed(cur.cnt) |-> $past(rise))
        else $error("bit count moved without a line clock rise");

endmodule

// ===== ofc_link_top.sv
// Out-of-band flow control link: transmit end, receive end, register slave
//
// Local design decisions: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`include "ofc_defines.svh"

module ofc_link_top
    import ofc_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [7:0]            wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic [31:0]                wb_dat_o,
    output logic                       wb_ack_o,
    input  wire logic                  ena_status_i,
    input  wire logic [15:0]           calendar_i,
    input  wire logic [`OFC_LANES-1:0] lane_status_i,
    input  wire logic                  link_status_i,
    output logic                       oob_tx_line_clock_o,
    output logic                       oob_tx_serial_bit_o,
    output logic                       oob_tx_frame_mark_o,
    input  wire logic                  oob_rx_line_clock_i,
    input  wire logic                  oob_rx_serial_bit_i,
    input  wire logic                  oob_rx_frame_mark_i,
    output logic [15:0]                rx_calendar_o,
    output logic [`OFC_LANES-1:0]      rx_lane_status_o,
    output logic                       rx_link_status_o,
    output logic                       rx_calendar_update_o,
    output logic                       rx_calendar_error_o,
    output logic                       rx_status_update_o,
    output logic                       rx_status_error_o
);

    ofc_top_state_t cur;
    ofc_top_state_t nxt;
    logic           b;
    logic [15:0]    sh;
    logic [3:0]     crc;
    logic           req;
    logic [3:0]     ev_set;
    logic [3:0]     ev_clr;

    ////////////////////////////////////////////////////////////////////////
    // Receive end
    ofc_rx_core u_rx (
        .clk_i               (clk_i),
        .rst_i               (rst_i),
        .oob_rx_line_clock_i (oob_rx_line_clock_i),
        .oob_rx_serial_bit_i (oob_rx_serial_bit_i),
        .oob_rx_frame_mark_i (oob_rx_frame_mark_i),
        .calendar_o          (rx_calendar_o),
        .lane_status_o       (rx_lane_status_o),
        .link_status_o       (rx_link_status_o),
        .calendar_update_o   (rx_calendar_update_o),
        .calendar_error_o    (rx_calendar_error_o),
        .status_update_o     (rx_status_update_o),
        .status_error_o      (rx_status_error_o)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        nxt          = cur;
        b            = cur.ser_bit;
        sh           = cur.shreg;
        crc          = cur.crc;
        nxt.line_clk = ~cur.line_clk;
        if (cur.line_clk)
        begin
            nxt.mark = 1'b0;
            case (cur.phase)
                TX_CAL:
                begin
                    if (cur.cnt == 6'h00 && !cur.run)
                        b = 1'b0;
                    else
                    begin
                        if (cur.cnt == 6'h00)
                        begin
                            // Frame start latches the application words
                            sh            = calendar_i;
                            crc           = `OFC_CRC_INIT;
                            nxt.stat      = {link_status_i, lane_status_i};
                            nxt.with_stat = ena_status_i;
                            nxt.snap_cal  = calendar_i;
                            nxt.mark      = 1'b1;
                        end
                        b   = sh[15];
                        sh  = {sh[14:0], 1'b0};
                        crc = ofc_crc_step(crc, b);
                        if (cur.cnt == `OFC_CAL_LAST)
                        begin
                            nxt.phase = TX_CAL_CRC;
                            nxt.cnt   = 6'h00;
                        end
                        else
                            nxt.cnt = cur.cnt + 6'h01;
                    end
                end
                TX_CAL_CRC:
                begin
                    b   = crc[3];
                    crc = {crc[2:0], 1'b0};
                    if (cur.cnt == `OFC_CRC_LAST)
                    begin
                        nxt.cnt = 6'h00;
                        if (cur.with_stat)
                        begin
                            nxt.phase = TX_STAT;
                            sh        = {cur.stat, 7'h00};
                            crc       = `OFC_CRC_INIT;
                        end
                        else
                            nxt.phase = TX_CAL;
                    end
                    else
                        nxt.cnt = cur.cnt + 6'h01;
                end
                TX_STAT:
                begin
                    b   = sh[15];
                    sh  = {sh[14:0], 1'b0};
                    crc = ofc_crc_step(crc, b);
                    if (cur.cnt == `OFC_STAT_LAST)
                    begin
                        nxt.phase = TX_STAT_CRC;
                        nxt.cnt   = 6'h00;
                    end
                    else
                        nxt.cnt = cur.cnt + 6'h01;
                end
                default:
                begin
                    b   = crc[3];
                    crc = {crc[2:0], 1'b0};
                    if (cur.cnt == `OFC_CRC_LAST)
                    begin
                        nxt.phase = TX_CAL;
                        nxt.cnt   = 6'h00;
                    end
                    else
                        nxt.cnt = cur.cnt + 6'h01;
                end
            endcase
            nxt.ser_bit = b;
        end
        nxt.shreg = sh;
        nxt.crc   = crc;

        // Register slave
        req     = wb_cyc_i & wb_stb_i & ~cur.ack;
        ev_set  = {rx_status_error_o, rx_status_update_o,
                   rx_calendar_error_o, rx_calendar_update_o};
        ev_clr  = 4'h0;
        nxt.ack = req;
        if (req)
        begin
            nxt.dat = 32'h0000_0000;
            if (wb_we_i)
            begin
                if (wb_adr_i == `OFC_ADR_CTRL && wb_sel_i[0])
                    nxt.run = wb_dat_i[`OFC_CTRL_RUN];
                else if (wb_adr_i == `OFC_ADR_EVENTS && wb_sel_i[0])
                    ev_clr = wb_dat_i[3:0];
            end
            else if (wb_adr_i == `OFC_ADR_CTRL)
                nxt.dat = {31'h0000_0000, cur.run};
            else if (wb_adr_i == `OFC_ADR_TX_SNAP)
                nxt.dat = {15'h0000, cur.with_stat, cur.snap_cal};
            else if (wb_adr_i == `OFC_ADR_RX_CAL)
                nxt.dat = {16'h0000, rx_calendar_o};
            else if (wb_adr_i == `OFC_ADR_RX_STAT)
                nxt.dat = {23'h00_0000, rx_link_status_o, rx_lane_status_o};
            else if (wb_adr_i == `OFC_ADR_EVENTS)
                nxt.dat = {28'h000_0000, cur.events};
        end
        // A new event wins over a clear in the same cycle
        nxt.events = (cur.events & ~ev_clr) | ev_set;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cur        <= '0;
            cur.run    <= `OFC_CTRL_RESET;
            cur.events <= `OFC_EVENTS_RESET;
        end
        else
            cur <= nxt;
    end

    assign oob_tx_line_clock_o = cur.line_clk;
    assign oob_tx_serial_bit_o = cur.ser_bit;
    assign oob_tx_frame_mark_o = cur.mark;
    assign wb_ack_o            = cur.ack;
    assign wb_dat_o            = cur.dat;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_line_clk_half: assert property (
        oob_tx_line_clock_o |=> !oob_tx_line_clock_o ##1 oob_tx_line_clock_o)
        else $error("line clock is not half the system clock");

    chk_bit_on_fall: assert property (
        ($changed(oob_tx_serial_bit_o) || $changed(oob_tx_frame_mark_o))
            |-> $fell(oob_tx_line_clock_o))
        else $error("link outputs moved away from the falling edge");

    chk_mark_one_bit: assert property (
        $rose(oob_tx_frame_mark_o) |->
            ##1 oob_tx_frame_mark_o ##1 !oob_tx_frame_mark_o)
        else $error("frame mark is not one bit long");

    chk_frame_first_bit: assert property (
        $rose(oob_tx_frame_mark_o) |->
            oob_tx_serial_bit_o == $past(calendar_i[15]))
        else $error("first frame bit is not the calendar msb");

    chk_cal_only_len: assert property (
        ($rose(oob_tx_frame_mark_o) && !$past(ena_status_i)) |->
            ##40 (oob_tx_frame_mark_o || !cur.run))
        else $error("calendar-only frame has the wrong length");

    chk_stat_frame_len: assert property (
        ($rose(oob_tx_frame_mark_o) && $past(ena_status_i)) |->
            ##40 !oob_tx_frame_mark_o ##26 (oob_tx_frame_mark_o || !cur.run))
        else $error("frame with status has the wrong length");

    chk_ack_follows: assert property (
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer is not a single cycle after the request");

    chk_run_steers: assert property (
        (!cur.run && cur.phase == TX_CAL && cur.cnt == 6'h00) |=>
            !oob_tx_frame_mark_o)
        else $error("frame started while the transmitter is stopped");

endmodule

// ===== ofc_far_end.sv
// Link partner model: upstream transmitter driving the receive pins
`timescale 1ns/1ps

module ofc_far_end
(
    output logic line_clk_o,
    output logic ser_bit_o,
    output logic mark_o
);

    initial
    begin
        line_clk_o = 1'b0;
        ser_bit_o  = 1'b1;
        mark_o     = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // Check code over the low n bits of v, most significant bit first
    function automatic logic [3:0] crc4(input logic [19:0] v,
                                        input int          n);
        logic [3:0] c;
        c = 4'hf;
        for (int i = n - 1; i >= 0; i--)
            c = {c[2:0], 1'b0} ^ ((c[3] ^ v[i]) ? 4'h3 : 4'h0);
        return c;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // One frame at 160 ns per bit; clock stands still between frames
    task automatic send(input logic [15:0] cal, input logic [8:0] st,
                        input logic ws, input logic [1:0] bad);
        logic [32:0] f;
        f = {cal, crc4({4'h0, cal}, 16) ^ {3'h0, bad[0]},
             st, crc4({11'h0, st}, 9) ^ {3'h0, bad[1]}};
        #1.3;
        for (int i = 32; i >= (ws ? 0 : 13); i--)
        begin
            ser_bit_o = f[i];
            mark_o    = (i == 32);
            #80 line_clk_o = 1'b1;
            #80 line_clk_o = 1'b0;
        end
        mark_o    = 1'b0;
        ser_bit_o = ~ser_bit_o;
    endtask

endmodule

// ===== testbench.sv
// Self-checking bench for the flow control link top
`timescale 1ns/1ps
`include "ofc_defines.svh"

module testbench;

    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, ena = 1'b0;
    logic [7:0]  adr = 8'h00, lane = 8'h00, rlane;
    logic [31:0] wdat = 32'h0000_0000, rdat;
    logic [15:0] cal = 16'h0000, rcal;
    logic        link = 1'b0, rlink, cu, ce, su, se;
    logic        tlc, tbit, tmark, flc, fbit, fmark;
    logic        lc_q = 1'b0, bit_q = 1'b0, rq = 1'b1;
    logic [32:0] fr = 33'h0, last = 33'h0;
    int          fn = 0, last_n = 0, marks = 0, cycles = 0;
    int          bad_count = 0, n_checks = 0;
    int          ev[4] = '{0, 0, 0, 0};

    always #2.5 clk_i = ~clk_i;

    ofc_link_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .ena_status_i(ena), .calendar_i(cal), .lane_status_i(lane),
        .link_status_i(link), .oob_tx_line_clock_o(tlc),
        .oob_tx_serial_bit_o(tbit), .oob_tx_frame_mark_o(tmark),
        .oob_rx_line_clock_i(flc), .oob_rx_serial_bit_i(fbit),
        .oob_rx_frame_mark_i(fmark), .rx_calendar_o(rcal),
        .rx_lane_status_o(rlane), .rx_link_status_o(rlink),
        .rx_calendar_update_o(cu), .rx_calendar_error_o(ce),
        .rx_status_update_o(su), .rx_status_error_o(se));

    ofc_far_end far (.line_clk_o(flc), .ser_bit_o(fbit), .mark_o(fmark));

    ////////////////////////////////////////////////////////////////////
    task automatic test_done;
        if (bad_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, what,
                     got, exp);
        end
    endtask

    task automatic wb(input logic [7:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] q);
        int t;
        t = 0;
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do
        begin
            @(posedge clk_i);
            t++;
        end while (ack !== 1'b1 && t < 64);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        check({31'h0, ack}, 32'h1, "bus answer");
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                      input string what);
        logic [31:0] q;
        wb(a, 1'b0, 32'h0000_0000, q);
        check(q, exp, what);
    endtask

    ////////////////////////////////////////////////////////////////////
    // Watches the transmit pins and the receive pulses
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles > 40000)
        begin
            bad_count++;
            test_done();
        end
        if (rq === 1'b0 && tlc !== ~lc_q)
            check({31'h0, tlc}, {31'h0, ~lc_q}, "line clock");
        if (rq === 1'b0 && tbit !== bit_q && !(lc_q && !tlc))
            check({31'h0, tbit}, {31'h0, bit_q}, "bit timing");
        if (lc_q === 1'b0 && tlc === 1'b1)
        begin
            if (tmark === 1'b1)
            begin
                last   = fr;
                last_n = fn;
                marks++;
                fr = {32'h0, tbit};
                fn = 1;
            end
            else if (fn > 0 && fn < 33)
            begin
                fr = {fr[31:0], tbit};
                fn++;
            end
        end
        if ((cu & ce) === 1'b1 || (su & se) === 1'b1)
            check(32'h1, 32'h0, "both pulses");
        ev[0] += (cu === 1'b1);
        ev[1] += (ce === 1'b1);
        ev[2] += (su === 1'b1);
        ev[3] += (se === 1'b1);
        lc_q  = tlc;
        bit_q = tbit;
        rq    = rst_i;
    end

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [31:0] q;
        logic [15:0] c;
        logic [7:0]  l;
        logic [1:0]  bad;
        logic        ws, n;
        int          e[4];
        void'($urandom(32'hb4e9));
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (100) @(posedge clk_i);
        rd(`OFC_ADR_CTRL, 32'h0, "ctrl reset");
        rd(`OFC_ADR_TX_SNAP, 32'h0, "snap reset");
        rd(`OFC_ADR_RX_CAL, 32'h0, "rx cal reset");
        rd(`OFC_ADR_RX_STAT, 32'h0, "rx stat reset");
        rd(`OFC_ADR_EVENTS, 32'h0, "events reset");
        wb(8'h20, 1'b1, 32'hffff_ffff, q);
        rd(8'h20, 32'h0, "unmapped");
        check(marks, 0, "frames while stopped");
        wb(`OFC_ADR_CTRL, 1'b1, 32'h1, q);
        rd(`OFC_ADR_CTRL, 32'h1, "ctrl run");
        for (int k = 0; k < 6; k++)
        begin
            ena  <= k[0];
            cal  <= (k == 0) ? 16'h0000 : (k == 1) ? 16'hffff
                                                    : 16'($urandom);
            lane <= 8'($urandom);
            link <= 1'($urandom);
            repeat (160) @(posedge clk_i);
            check(last_n, k[0] ? 33 : 20, "frame length");
            check({16'h0, last[last_n-1 -: 16]}, {16'h0, cal}, "cal");
            check(far.crc4(last[last_n-1 -: 20], 20), 0, "crc");
            if (k[0])
            begin
                check({23'h0, last[12:4]}, {23'h0, link, lane}, "st");
                check(far.crc4({7'h0, last[12:0]}, 13), 0, "st crc");
            end
            rd(`OFC_ADR_TX_SNAP, {15'h0, k[0], cal}, "snap");
        end
        wb(`OFC_ADR_CTRL, 1'b1, 32'h0, q);
        repeat (100) @(posedge clk_i);
        n = 1'b0;
        e[0] = marks;
        repeat (200) @(posedge clk_i);
        check(marks, e[0], "frames after stop");
        for (int k = 0; k < 8; k++)
        begin
            bad = 2'($urandom);
            ws  = (k < 4) ? 1'b1 : 1'($urandom);
            if (k < 4)
                bad = 2'(k);
            c = 16'($urandom);
            l = 8'($urandom);
            n = 1'($urandom);
            e = ev;
            far.send(c, {n, l}, ws, bad);
            check(ev[0] - e[0], !bad[0], "cal ok");
            check(ev[1] - e[1], bad[0], "cal err");
            check(ev[2] - e[2], ws & !bad[1], "st ok");
            check(ev[3] - e[3], ws & bad[1], "st err");
            check({16'h0, rcal}, {16'h0, c}, "rx cal");
            if (ws)
                check({23'h0, rlink, rlane}, {23'h0, n, l}, "rx st");
            rd(`OFC_ADR_RX_CAL, {16'h0, c}, "rx cal reg");
            rd(`OFC_ADR_EVENTS, {28'h0, ws & bad[1], ws & !bad[1], bad[0],
               !bad[0]}, "events");
            wb(`OFC_ADR_EVENTS, 1'b1, 32'hf, q);
            rd(`OFC_ADR_EVENTS, 32'h0, "events clear");
        end
        test_done();
    end

endmodule
